// *** core/fsp_pkg.sv ***
package fsp_pkg;
  // ---------------------------------------------------------------
  // flash geometry
  // ---------------------------------------------------------------
  localparam int unsigned WORD_ADDR_W = 15;
  localparam int unsigned PAGE_W = 8;
  // first word of the halting section (upper part of flash)
  localparam logic [14:0] HALT_BASE = 15'h7000;
  // boot part start per boot size fuse code (2 bits)
  localparam logic [14:0] BOOT_BASE_0 = 15'h7000;
  localparam logic [14:0] BOOT_BASE_1 = 15'h7800;
  localparam logic [14:0] BOOT_BASE_2 = 15'h7C00;
  localparam logic [14:0] BOOT_BASE_3 = 15'h7E00;
  // ---------------------------------------------------------------
  // lock modes (two bits per set, 1 = unprogrammed)
  // ---------------------------------------------------------------
  localparam int unsigned LOCK_WR_BIT = 0;
  localparam int unsigned LOCK_RD_BIT = 1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned PROG_TIME_NS = 4000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  typedef enum logic [1:0] {FSP_CMD_ERASE, FSP_CMD_WRITE,
    FSP_CMD_LOCK, FSP_CMD_OTHER} fsp_cmd_t;
endpackage

// *** core/fsp_region_if.sv ***
`timescale 1ns/100ps
interface fsp_region_if;
  logic [fsp_pkg::WORD_ADDR_W-1:0] addr;
  logic [1:0] boot_size;
  logic in_boot;
  logic in_halt;
  modport owner (output addr, output boot_size, input in_boot,
    input in_halt);
  modport decoder (input addr, input boot_size, output in_boot,
    output in_halt);
endinterface

// *** core/fsp_region_dec.sv ***
`timescale 1ns/100ps
module fsp_region_dec
(
  fsp_region_if.decoder rg
);
  logic [fsp_pkg::WORD_ADDR_W-1:0] boot_base;

  always_comb
  begin
    case (rg.boot_size)
      2'h0: boot_base = fsp_pkg::BOOT_BASE_0;
      2'h1: boot_base = fsp_pkg::BOOT_BASE_1;
      2'h2: boot_base = fsp_pkg::BOOT_BASE_2;
      default: boot_base = fsp_pkg::BOOT_BASE_3;
    endcase
  end

  assign rg.in_boot = (rg.addr >= boot_base);
  assign rg.in_halt = (rg.addr >= fsp_pkg::HALT_BASE);
endmodule

// *** core/fsp_sequencer.sv ***
// What this block does
// - fuse-selected boundary splits flash into application and boot parts.
// - self-write fetched from the application part is refused.
// - self-write from the boot part may target any flash address.
// - lock set 0 guards application, set 1 guards boot, independently.
// - a fixed boundary splits flash into concurrent-read and halting sections.
// - programming concurrent section keeps the cpu running.
// - programming halting section stalls cpu for the whole operation.
// - boot part always lies inside the halting section.
// - busy flag reads one while concurrent-section reads are blocked.
// - busy flag stays set after programming until software clears it.
// - behaviour follows the target page section, not the fetch section.
// - target page is latched when an operation starts.
`timescale 1ns/100ps
module fsp_sequencer
#(
  parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // fuses and locks
  input wire logic [1:0] boot_size_fuses,
  input wire logic [1:0] app_lock,
  input wire logic [1:0] boot_lock,
  // cpu request
  input wire logic self_write_req,
  input wire fsp_pkg::fsp_cmd_t self_write_cmd,
  input wire logic [fsp_pkg::WORD_ADDR_W-1:0] fetch_addr,
  input wire logic [fsp_pkg::WORD_ADDR_W-1:0] target_addr,
  input wire logic busy_clear,
  // status
  output logic cpu_stall,
  output logic concurrent_section_busy,
  output logic prog_active,
  output logic refused,
  output logic [fsp_pkg::WORD_ADDR_W-1:0] latched_addr
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // region decode for fetch and target
  // ---------------------------------------------------------------
  fsp_region_if fetch_rg();
  fsp_region_if tgt_rg();

  assign fetch_rg.addr = fetch_addr;
  assign fetch_rg.boot_size = boot_size_fuses;
  assign tgt_rg.addr = target_addr;
  assign tgt_rg.boot_size = boot_size_fuses;

  fsp_region_dec u_fetch_dec (.rg(fetch_rg));
  fsp_region_dec u_tgt_dec (.rg(tgt_rg));

  // ---------------------------------------------------------------
  // start qualification
  // ---------------------------------------------------------------
  typedef enum logic {FSP_IDLE, FSP_BUSY} fsp_state_t;
  fsp_state_t state_q;
  logic is_prog;
  logic lock_ok;
  logic start;
  logic reject;

  assign is_prog = (self_write_cmd == fsp_pkg::FSP_CMD_ERASE) ||
                   (self_write_cmd == fsp_pkg::FSP_CMD_WRITE);
  // target part picks its own lock set, the other one is ignored
  assign lock_ok = tgt_rg.in_boot ? boot_lock[fsp_pkg::LOCK_WR_BIT]
                                  : app_lock[fsp_pkg::LOCK_WR_BIT];
  // any target allowed once the fetch sits in the boot part
  assign start = self_write_req && is_prog && (state_q == FSP_IDLE) &&
                 fetch_rg.in_boot && lock_ok;
  assign reject = self_write_req && is_prog && !start;

  // ---------------------------------------------------------------
  // operation sequencing
  // ---------------------------------------------------------------
  logic [fsp_pkg::CNT_W-1:0] cnt_q;
  logic tgt_halt_q;
  logic done;

  assign done = (state_q == FSP_BUSY) &&
                (cnt_q == fsp_pkg::CNT_W'(PROG_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= FSP_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        FSP_IDLE:
          if (start)
          begin
            state_q <= FSP_BUSY;
            cnt_q <= '0;
          end
        FSP_BUSY:
          if (done)
            state_q <= FSP_IDLE;
          else
            cnt_q <= cnt_q + 1'b1;
        default:
          state_q <= FSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      latched_addr <= '0;
      tgt_halt_q <= 1'b0;
    end
    else if (start)
    begin
      latched_addr <= target_addr;
      tgt_halt_q <= tgt_rg.in_halt;
    end
  end

  // ---------------------------------------------------------------
  // stall, busy and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cpu_stall <= 1'b0;
    else if (start)
      cpu_stall <= tgt_rg.in_halt;
    else if (done)
      cpu_stall <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      concurrent_section_busy <= 1'b0;
    else if (start && !tgt_rg.in_halt)
      concurrent_section_busy <= 1'b1;
    else if (busy_clear && state_q == FSP_IDLE)
      concurrent_section_busy <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      prog_active <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      prog_active <= start || (state_q == FSP_BUSY && !done);
      refused <= reject;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start_halt;
    start && tgt_rg.in_halt;
  endsequence

  sequence s_start_conc;
    start && !tgt_rg.in_halt;
  endsequence

  chk_app_refuse: assert property (@(posedge clock) disable iff (!rst_n_q)
    self_write_req && is_prog && !fetch_rg.in_boot |=> refused && !$rose(prog_active))
    else $error("self-write from application part was not refused");

  chk_halt_stall: assert property (@(posedge clock) disable iff (!rst_n_q)
    s_start_halt |=> cpu_stall [*8])
    else $error("cpu not stalled during halting-section programming");

  chk_conc_run: assert property (@(posedge clock) disable iff (!rst_n_q)
    s_start_conc |=> !cpu_stall && concurrent_section_busy)
    else $error("cpu stalled or busy low for concurrent programming");

  chk_busy_hold: assert property (@(posedge clock) disable iff (!rst_n_q)
    concurrent_section_busy && !busy_clear |=> concurrent_section_busy)
    else $error("busy flag dropped without software clear");

  chk_busy_during: assert property (@(posedge clock) disable iff (!rst_n_q)
    prog_active && !tgt_halt_q |-> concurrent_section_busy)
    else $error("busy flag low while concurrent section programmed");

  chk_addr_latch: assert property (@(posedge clock) disable iff (!rst_n_q)
    start |=> latched_addr == $past(target_addr))
    else $error("target page not latched at start");

  chk_addr_hold: assert property (@(posedge clock) disable iff (!rst_n_q)
    state_q == FSP_BUSY && !start |=> $stable(latched_addr))
    else $error("latched address changed during operation");

  chk_stall_end: assert property (@(posedge clock) disable iff (!rst_n_q)
    done |=> !cpu_stall)
    else $error("stall not released at operation end");

  chk_boot_halt: assert property (@(posedge clock) disable iff (!rst_n_q)
    fetch_rg.in_boot |-> fetch_rg.in_halt)
    else $error("boot part outside halting section");

  chk_lock_block: assert property (@(posedge clock) disable iff (!rst_n_q)
    self_write_req && tgt_rg.in_boot && !boot_lock[0] |-> !start)
    else $error("write into locked boot part started");

  chk_app_lock: assert property (@(posedge clock) disable iff (!rst_n_q)
    self_write_req && !tgt_rg.in_boot &&
    !app_lock[fsp_pkg::LOCK_WR_BIT] |-> !start)
    else $error("write into locked application part started");
endmodule

// *** sim/fsp_cpu_model.sv ***
`timescale 1ns/100ps
module fsp_cpu_model
(
  // clock
  input wire logic clock,
  // self-write request side
  output logic self_write_req,
  output fsp_pkg::fsp_cmd_t self_write_cmd,
  output logic [14:0] fetch_addr,
  output logic [14:0] target_addr,
  output logic busy_clear
);
  // ---------------------------------------------------------------
  // boot firmware issuing self-write operations
  // ---------------------------------------------------------------
  initial
  begin
    self_write_req = 1'b0;
    self_write_cmd = fsp_pkg::FSP_CMD_OTHER;
    fetch_addr = 15'h7e00;
    target_addr = 15'h0000;
    busy_clear = 1'b0;
  end

  // one request cycle; returns once the answer is visible
  task automatic issue(input fsp_pkg::fsp_cmd_t c, input logic [14:0] f,
    input logic [14:0] t);
    @(negedge clock);
    self_write_req = 1'b1;
    self_write_cmd = c;
    fetch_addr = f;
    target_addr = t;
    @(negedge clock);
    self_write_req = 1'b0;
    // pointer reused for other work after the start
    target_addr = ~t;
    // keep fetching from the issuing code, never the busy section
    fetch_addr = f;
  endtask

  // firmware clears the busy flag before touching that section again
  task automatic clear_busy();
    @(negedge clock);
    busy_clear = 1'b1;
    @(negedge clock);
    busy_clear = 1'b0;
    @(negedge clock);
  endtask
endmodule

// *** sim/flash_self_program_sections_test.sv ***
`timescale 1ns/100ps
module flash_self_program_sections_test;
  localparam int unsigned PC = 8;
  logic clock;
  logic reset_n;
  logic [1:0] boot_size_fuses;
  logic [1:0] app_lock;
  logic [1:0] boot_lock;
  logic self_write_req;
  fsp_pkg::fsp_cmd_t self_write_cmd;
  logic [14:0] fetch_addr;
  logic [14:0] target_addr;
  logic busy_clear;
  logic cpu_stall;
  logic concurrent_section_busy;
  logic prog_active;
  logic refused;
  logic [14:0] latched_addr;
  logic [14:0] bases [4];
  int fails;
  int comparisons;

`define CHK(a, e) \
  comparisons++; \
  if ((a) !== (e)) \
  begin \
    fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); \
  end

  fsp_cpu_model cpu (.clock(clock), .self_write_req(self_write_req),
    .self_write_cmd(self_write_cmd), .fetch_addr(fetch_addr),
    .target_addr(target_addr), .busy_clear(busy_clear));

  fsp_sequencer #(.PROG_CYCLES(PC)) fsp_sequencer_inst (.clock(clock),
    .reset_n(reset_n), .boot_size_fuses(boot_size_fuses),
    .app_lock(app_lock), .boot_lock(boot_lock),
    .self_write_req(self_write_req), .self_write_cmd(self_write_cmd),
    .fetch_addr(fetch_addr), .target_addr(target_addr),
    .busy_clear(busy_clear), .cpu_stall(cpu_stall),
    .concurrent_section_busy(concurrent_section_busy),
    .prog_active(prog_active), .refused(refused),
    .latched_addr(latched_addr));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one operation, checked from start to end
  task automatic run_op(input fsp_pkg::fsp_cmd_t c, input logic [14:0] f,
    input logic [14:0] t, input logic acc, input logic stall,
    input logic busy);
    cpu.issue(c, f, t);
    `CHK(refused, ~acc)
    `CHK(prog_active, acc)
    `CHK(cpu_stall, stall)
    `CHK(concurrent_section_busy, busy)
    if (acc)
    begin
      `CHK(latched_addr, t)
      repeat (PC - 1) @(negedge clock);
      `CHK(prog_active, 1'b1)
      `CHK(cpu_stall, stall)
      @(negedge clock);
      `CHK(prog_active, 1'b0)
      `CHK(cpu_stall, 1'b0)
      `CHK(concurrent_section_busy, busy)
      `CHK(latched_addr, t)
    end
  endtask

  initial
  begin
    fails = 0;
    comparisons = 0;
    bases = '{fsp_pkg::BOOT_BASE_0, fsp_pkg::BOOT_BASE_1,
      fsp_pkg::BOOT_BASE_2, fsp_pkg::BOOT_BASE_3};
    reset_n = 1'b0;
    boot_size_fuses = 2'h3;
    app_lock = 2'h3;
    boot_lock = 2'h3;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(prog_active, 1'b0)
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h7100, 1, 1, 0);
    run_op(fsp_pkg::FSP_CMD_ERASE, 15'h7f00, 15'h0100, 1, 0, 1);
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7f00, 15'h0140, 1, 0, 1);
    cpu.clear_busy();
    `CHK(concurrent_section_busy, 1'b0)
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h1000, 15'h7100, 0, 0, 0);
    cpu.issue(fsp_pkg::FSP_CMD_LOCK, 15'h7e00, 15'h7100);
    `CHK({refused, prog_active}, 2'h0)
    for (int i = 0; i < 4; i++)
    begin
      boot_size_fuses = i[1:0];
      run_op(fsp_pkg::FSP_CMD_WRITE, bases[i] - 15'h0001, 15'h7100, 0, 0,
        0);
      run_op(fsp_pkg::FSP_CMD_WRITE, bases[i], 15'h7100, 1, 1, 0);
    end
    app_lock = 2'h2;
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h0200, 0, 0, 0);
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h7f00, 1, 1, 0);
    app_lock = 2'h3;
    boot_lock = 2'h2;
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h7f00, 0, 0, 0);
    run_op(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h0200, 1, 0, 1);
    // second request while busy is refused, first page stays latched
    cpu.issue(fsp_pkg::FSP_CMD_ERASE, 15'h7e00, 15'h0300);
    cpu.issue(fsp_pkg::FSP_CMD_WRITE, 15'h7e00, 15'h0400);
    `CHK({refused, prog_active}, 2'h3)
    `CHK(latched_addr, 15'h0300)
    cpu.clear_busy();
    `CHK(concurrent_section_busy, 1'b1)
    repeat (PC) @(negedge clock);
    `CHK({prog_active, latched_addr}, {1'b0, 15'h0300})
    cpu.clear_busy();
    `CHK(concurrent_section_busy, 1'b0)
    report_and_stop();
  end

  // hang guard, well beyond the roughly 140 cycles the tests need
  initial
  begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule
